// ===== design/cal_state_field_defs.svh
// register offsets, field positions, reset values and timing counts of the calibration memory control
`ifndef CAL_STATE_FIELD_DEFS_SVH
`define CAL_STATE_FIELD_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define CAL_CFG_OFFSET       8'h0e
`define CAL_CTRL_OFFSET      8'h0f
`define TRIM_ADDR_OFFSET     8'h10
`define TRIM_DATA_OFFSET     8'h11

// ****************************************
// calibration control fields
// ****************************************
`define SELF_CAL_DONE_BIT    7
`define START_SELF_CAL_BIT   6
`define COPY_DONE_BIT        5
`define START_COPY_BIT       4
`define WORK_WR_EN_BIT       3
`define WORK_RD_EN_BIT       2
`define FACT_RD_EN_BIT       1
`define FORCE_DEFAULT_BIT    0

// ****************************************
// calibration configuration fields
// ****************************************
`define CAL_STATE_LSB        4
`define CAL_DIV_LSB          0

// ****************************************
// reset and default values
// ****************************************
`define TRIM_ADDR_RESET      8'h00
`define TRIM_DATA_RESET      6'h00
`define TRIM_DEFAULT_VALUE   6'h3f
`define CAL_DIV_RESET        3'h0

// ****************************************
// timing
// ****************************************
// durations are given at a 100 MHz converter clock with the slowest divider
`define SELF_CAL_TIME_MS     100
`define COPY_TIME_MS         15
`define REF_CLOCK_MHZ        100
`define SLOWEST_DIVIDE       4096
`define SELF_CAL_TICKS       ((`SELF_CAL_TIME_MS * 1000 * `REF_CLOCK_MHZ) / `SLOWEST_DIVIDE)
`define COPY_TICKS           ((`COPY_TIME_MS * 1000 * `REF_CLOCK_MHZ) / `SLOWEST_DIVIDE)

`endif

// ===== design/cal_state_field_pkg.sv
// types shared by the calibration memory control files
package cal_state_field_pkg;

    // source of the working trim values
    typedef enum logic [1:0] {
        SRC_DEFAULT = 2'h0,
        SRC_SELF    = 2'h1,
        SRC_FACTORY = 2'h2,
        SRC_USER    = 2'h3
    } cal_source_type;

    // sequencer states
    typedef enum logic [1:0] {
        IDLE,
        SELF_CAL,
        COPY
    } cycle_state_type;

endpackage

// ===== design/cal_tick_gen.sv
// calibration clock divider producing one tick per divided period
`timescale 1ns/10ps
`default_nettype none

module cal_tick_gen
    import cal_state_field_pkg::*;
#(
    parameter int CODE_W = 3,
    parameter int CNT_W  = 12
) (
    input  wire logic              MCLK,
    input  wire logic              RESET_N,
    input  wire logic              RUN,
    input  wire logic [CODE_W-1:0] CODE,
    output logic                   TICK
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] last_count;

    // code 0 divides by 4096, each step halves down to 32 at code 7
    assign last_count = CNT_W'({CNT_W{1'b1}} >> CODE);

    // free count restarts whenever no cycle runs so the first tick is a full period
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            count_reg <= '0;
        end else if (!RUN || count_reg >= last_count) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign TICK = RUN && (count_reg >= last_count);

endmodule

`default_nettype wire

// ===== design/calibration_memory_control.sv
// calibration memory control: self-calibration, factory copy, default trim and indirect access
//
// Operation
// - writing one to start_self_cal launches a self-calibration filling working memory
// - copy_done_flag goes high when a factory-to-working copy finishes
// - writing one to start_factory_copy launches a factory-to-working copy
// - working_mem_write_en permits indirect writes into working memory
// - working_mem_read_en permits indirect reads of working memory
// - factory_mem_read_en permits indirect reads of factory memory
// - force_default_trim runs uncalibrated with every working location at default
// - force_default_trim stays set, holding defaults, until software writes zero
// - self-calibration lasts about 100 ms at 100 MHz with slowest divider
// - factory copy lasts about 15 ms at 100 MHz with slowest divider
// - the copy is paced by the divided calibration clock too
// - trim_mem_address is an 8-bit indirect location resetting to zero
// - trim_mem_data is 6-bit write and read data resetting to zero
// - soft reset self-clears, keeps working memory, reports uncalibrated state
// - self_cal_done_flag goes high when self-calibration completes
// - cal_state_field reports default, self, factory or user source
// - divider code 000 divides by 4096, halving per step to 32
`timescale 1ns/10ps
`default_nettype none
`include "cal_state_field_defs.svh"

module calibration_memory_control
    import cal_state_field_pkg::*;
#(
    parameter int DEPTH          = 256,
    parameter int ADDR_W         = 8,
    parameter int DATA_W         = 6,
    parameter int SELF_CAL_TICKS = `SELF_CAL_TICKS,
    parameter int COPY_TICKS     = `COPY_TICKS
) (
    input  wire logic              MCLK,
    input  wire logic              RESET_N,
    input  wire logic              SOFT_RESET,
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic [7:0]        REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic      [7:0]        REG_RDATA,
    output logic      [ADDR_W-1:0] FACTORY_ADDR,
    input  wire logic [DATA_W-1:0] FACTORY_DATA,
    input  wire logic [DATA_W-1:0] CAL_RESULT,
    input  wire logic [ADDR_W-1:0] TRIM_INDEX,
    output logic      [DATA_W-1:0] TRIM_VALUE,
    output logic                   CAL_BUSY
);

    // ****************************************
    // declarations
    // ****************************************
    localparam int TICK_W = 12;

    logic [ADDR_W-1:0]     trim_addr_reg;
    logic [DATA_W-1:0]     trim_data_reg;
    logic [2:0]            cal_div_reg;
    cal_source_type        cal_source_reg;
    cycle_state_type       state_reg;
    logic [TICK_W-1:0]     tick_count_reg;
    logic                  self_done_reg;
    logic                  copy_done_reg;
    logic                  work_wr_en_reg;
    logic                  work_rd_en_reg;
    logic                  fact_rd_en_reg;
    logic                  force_default_reg;
    logic [DATA_W-1:0]     work_mem_reg [DEPTH];
    logic [DATA_W-1:0]     cal_meta_reg;
    logic [DATA_W-1:0]     cal_sync_reg;
    logic [7:0]            rdata_reg;
    logic [DATA_W-1:0]     trim_value_reg;
    logic                  cal_tick;
    logic                  ctrl_wr;
    logic                  start_self;
    logic                  start_copy;
    logic                  cycle_end;
    logic                  user_write;
    logic                  fill_active;
    logic [ADDR_W-1:0]     fill_addr;
    logic [7:0]            ctrl_view;
    logic [7:0]            cfg_view;
    logic [DATA_W-1:0]     data_view;

    // one decoder shared by write and read paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction

    // ****************************************
    // request decode
    // ****************************************
    assign ctrl_wr    = REG_WR && hit(REG_ADDR, `CAL_CTRL_OFFSET);
    // a start whose write data sets any enable bit is ignored; an accepted start write clears the enables
    assign start_self = ctrl_wr && REG_WDATA[`START_SELF_CAL_BIT] && REG_WDATA[3:0] == 4'h0
                        && !REG_WDATA[`START_COPY_BIT] && state_reg == IDLE;
    assign start_copy = ctrl_wr && REG_WDATA[`START_COPY_BIT] && REG_WDATA[3:0] == 4'h0
                        && !REG_WDATA[`START_SELF_CAL_BIT] && state_reg == IDLE;
    assign user_write = REG_WR && hit(REG_ADDR, `TRIM_DATA_OFFSET) && work_wr_en_reg
                        && state_reg == IDLE;
    assign CAL_BUSY   = state_reg != IDLE;

    // ****************************************
    // divided calibration clock
    // ****************************************
    cal_tick_gen #(
        .CODE_W (3),
        .CNT_W  (TICK_W)
    ) u_tick (
        .MCLK    (MCLK),
        .RESET_N (RESET_N),
        .RUN     (CAL_BUSY),
        .CODE    (cal_div_reg),
        .TICK    (cal_tick)
    );

    // ****************************************
    // measurement input synchroniser
    // ****************************************
    // the analog result settles asynchronously, so it passes two stages first
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cal_meta_reg <= '0;
            cal_sync_reg <= '0;
        end else begin
            cal_meta_reg <= CAL_RESULT;
            cal_sync_reg <= cal_meta_reg;
        end
    end

    // ****************************************
    // cycle sequencer
    // ****************************************
    // a soft reset on the last tick still aborts, so no done flag is raised
    assign cycle_end   = cal_tick && !SOFT_RESET && (state_reg == SELF_CAL
                         ? tick_count_reg == TICK_W'(SELF_CAL_TICKS - 1)
                         : tick_count_reg == TICK_W'(COPY_TICKS - 1));
    // one location moves per calibration tick, the rest of the cycle is settling time
    assign fill_active = cal_tick && tick_count_reg < TICK_W'(DEPTH);
    assign fill_addr   = tick_count_reg[ADDR_W-1:0];

    // soft reset aborts a running cycle; the memory keeps what it had
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg      <= IDLE;
            tick_count_reg <= '0;
        end else if (SOFT_RESET) begin
            state_reg      <= IDLE;
            tick_count_reg <= '0;
        end else begin
            case (state_reg)
                IDLE: begin
                    tick_count_reg <= '0;
                    if (start_self) begin
                        state_reg <= SELF_CAL;
                    end else if (start_copy) begin
                        state_reg <= COPY;
                    end
                end
                SELF_CAL, COPY: begin
                    if (cycle_end) begin
                        state_reg <= IDLE;
                    end else if (cal_tick) begin
                        tick_count_reg <= tick_count_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // completion flags
    // ****************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            self_done_reg <= 1'b0;
            copy_done_reg <= 1'b0;
        end else begin
            if (state_reg == SELF_CAL && cycle_end) begin
                self_done_reg <= 1'b1;
            end else if (start_self || start_copy) begin
                self_done_reg <= 1'b0;
            end
            if (state_reg == COPY && cycle_end) begin
                copy_done_reg <= 1'b1;
            end else if (start_self || start_copy) begin
                copy_done_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // control enables
    // ****************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            work_wr_en_reg    <= 1'b0;
            work_rd_en_reg    <= 1'b0;
            fact_rd_en_reg    <= 1'b0;
            force_default_reg <= 1'b0;
        end else if (ctrl_wr) begin
            work_wr_en_reg    <= REG_WDATA[`WORK_WR_EN_BIT];
            work_rd_en_reg    <= REG_WDATA[`WORK_RD_EN_BIT];
            fact_rd_en_reg    <= REG_WDATA[`FACT_RD_EN_BIT];
            force_default_reg <= REG_WDATA[`FORCE_DEFAULT_BIT];
        end
    end

    // ****************************************
    // indirect address, data and divider registers
    // ****************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trim_addr_reg <= `TRIM_ADDR_RESET;
            trim_data_reg <= `TRIM_DATA_RESET;
            cal_div_reg   <= `CAL_DIV_RESET;
        end else if (REG_WR) begin
            if (hit(REG_ADDR, `TRIM_ADDR_OFFSET)) begin
                trim_addr_reg <= REG_WDATA[ADDR_W-1:0];
            end
            if (hit(REG_ADDR, `TRIM_DATA_OFFSET)) begin
                trim_data_reg <= REG_WDATA[DATA_W-1:0];
            end
            if (hit(REG_ADDR, `CAL_CFG_OFFSET)) begin
                cal_div_reg <= REG_WDATA[`CAL_DIV_LSB +: 3];
            end
        end
    end

    // ****************************************
    // calibration source tracking
    // ****************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cal_source_reg <= SRC_DEFAULT;
        end else if (SOFT_RESET || force_default_reg) begin
            cal_source_reg <= SRC_DEFAULT;
        end else if (state_reg == SELF_CAL && cycle_end) begin
            cal_source_reg <= SRC_SELF;
        end else if (state_reg == COPY && cycle_end) begin
            cal_source_reg <= SRC_FACTORY;
        end else if (user_write) begin
            cal_source_reg <= SRC_USER;
        end
    end

    // ****************************************
    // working trim memory
    // ****************************************
    // the factory array is read through one address, shared by copy and indirect read
    assign FACTORY_ADDR = state_reg == COPY ? fill_addr : trim_addr_reg;

    // force default overrides every location each cycle, so it wins over any other write
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge MCLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    work_mem_reg[i] <= `TRIM_DEFAULT_VALUE;
                end else if (force_default_reg) begin
                    work_mem_reg[i] <= `TRIM_DEFAULT_VALUE;
                end else if (fill_active && fill_addr == ADDR_W'(i)) begin
                    if (state_reg == SELF_CAL) begin
                        work_mem_reg[i] <= cal_sync_reg;
                    end else begin
                        work_mem_reg[i] <= FACTORY_DATA;
                    end
                end else if (user_write && trim_addr_reg == ADDR_W'(i)) begin
                    work_mem_reg[i] <= REG_WDATA[DATA_W-1:0];
                end
            end
        end
    endgenerate

    // converter-side trim readout, one cycle behind the index
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trim_value_reg <= `TRIM_DEFAULT_VALUE;
        end else begin
            trim_value_reg <= work_mem_reg[TRIM_INDEX];
        end
    end
    assign TRIM_VALUE = trim_value_reg;

    // ****************************************
    // register readback
    // ****************************************
    always_comb begin
        ctrl_view = '0;
        ctrl_view[`SELF_CAL_DONE_BIT]  = self_done_reg;
        ctrl_view[`START_SELF_CAL_BIT] = state_reg == SELF_CAL;
        ctrl_view[`COPY_DONE_BIT]      = copy_done_reg;
        ctrl_view[`START_COPY_BIT]     = state_reg == COPY;
        ctrl_view[`WORK_WR_EN_BIT]     = work_wr_en_reg;
        ctrl_view[`WORK_RD_EN_BIT]     = work_rd_en_reg;
        ctrl_view[`FACT_RD_EN_BIT]     = fact_rd_en_reg;
        ctrl_view[`FORCE_DEFAULT_BIT]  = force_default_reg;
        cfg_view = '0;
        cfg_view[`CAL_STATE_LSB +: 2]  = cal_source_reg;
        cfg_view[`CAL_DIV_LSB +: 3]    = cal_div_reg;
        // memory contents show only while the matching read enable is set
        if (work_rd_en_reg) begin
            data_view = work_mem_reg[trim_addr_reg];
        end else if (fact_rd_en_reg) begin
            data_view = FACTORY_DATA;
        end else begin
            data_view = trim_data_reg;
        end
    end

    // answer registered one cycle after the read strobe; unmapped offsets read zero
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= 8'h00;
        end else if (REG_RD) begin
            if (hit(REG_ADDR, `CAL_CTRL_OFFSET)) begin
                rdata_reg <= ctrl_view;
            end else if (hit(REG_ADDR, `CAL_CFG_OFFSET)) begin
                rdata_reg <= cfg_view;
            end else if (hit(REG_ADDR, `TRIM_ADDR_OFFSET)) begin
                rdata_reg <= 8'(trim_addr_reg);
            end else if (hit(REG_ADDR, `TRIM_DATA_OFFSET)) begin
                rdata_reg <= 8'(data_view);
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end
    assign REG_RDATA = rdata_reg;

endmodule

`default_nettype wire

// ===== tb/cal_state_field_ctrl_sva.sv
// concurrent checks on the calibration memory control ports
`timescale 1ns/10ps
`default_nettype none
`include "cal_state_field_defs.svh"

module cal_state_field_ctrl_sva #(
    parameter int ADDR_W         = 8,
    parameter int DATA_W         = 6,
    parameter int SELF_CAL_TICKS = 300,
    parameter int COPY_TICKS     = 260
) (
    input wire logic              MCLK,
    input wire logic              RESET_N,
    input wire logic              SOFT_RESET,
    input wire logic [7:0]        REG_ADDR,
    input wire logic [7:0]        REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [7:0]        REG_RDATA,
    input wire logic [ADDR_W-1:0] FACTORY_ADDR,
    input wire logic [DATA_W-1:0] FACTORY_DATA,
    input wire logic [DATA_W-1:0] CAL_RESULT,
    input wire logic [ADDR_W-1:0] TRIM_INDEX,
    input wire logic [DATA_W-1:0] TRIM_VALUE,
    input wire logic              CAL_BUSY
);
    // ****************************************
    // helper logic
    // ****************************************
    localparam int MAX_TICKS = (SELF_CAL_TICKS > COPY_TICKS) ? SELF_CAL_TICKS : COPY_TICKS;
    logic [31:0] busy_cnt_reg;
    logic [2:0]  div_reg;
    logic        ctrl_wr;
    logic        ctrl_rd;
    // soft reset excluded, it may abort whatever the access starts
    assign ctrl_wr = REG_WR && (REG_ADDR == `CAL_CTRL_OFFSET) && !SOFT_RESET;
    assign ctrl_rd = REG_RD && (REG_ADDR == `CAL_CTRL_OFFSET) && !SOFT_RESET;
    // divider shadow from config writes, so the length bound follows the tick period
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_reg <= 3'h0;
        end else if (REG_WR && REG_ADDR == `CAL_CFG_OFFSET) begin
            div_reg <= REG_WDATA[2:0];
        end
    end
    // length of the running cycle, so a sequencer that never ends is caught
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_cnt_reg <= 32'h0;
        end else if (CAL_BUSY) begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        end else begin
            busy_cnt_reg <= 32'h0;
        end
    end
    default clocking main_cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // ****************************************
    // assertions
    // ****************************************
    self_launch_a: assert property (ctrl_wr && REG_WDATA == 8'h40 && !CAL_BUSY |=> CAL_BUSY)
        else $error("self calibration did not start");
    copy_launch_a: assert property (ctrl_wr && REG_WDATA == 8'h10 && !CAL_BUSY |=> CAL_BUSY)
        else $error("factory copy did not start");
    bad_start_a: assert property (ctrl_wr && (REG_WDATA[6] || REG_WDATA[4])
        && REG_WDATA[3:0] != 4'h0 && !CAL_BUSY |=> !CAL_BUSY) else $error("bad start accepted");
    rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
    unmapped_rd_a: assert property (REG_RD && !(REG_ADDR inside {8'h0e, 8'h0f, 8'h10, 8'h11})
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
    fact_addr_a: assert property (REG_WR && REG_ADDR == `TRIM_ADDR_OFFSET && !CAL_BUSY
        |=> FACTORY_ADDR == $past(REG_WDATA)) else $error("factory address not trim address");
    soft_abort_a: assert property (SOFT_RESET && !REG_WR |=> !CAL_BUSY)
        else $error("soft reset left a cycle running");
    busy_bound_a: assert property (busy_cnt_reg <=
        32'(MAX_TICKS) * (32'h1000 >> div_reg)) else $error("calibration cycle too long");
    force_hold_a: assert property (ctrl_wr && REG_WDATA[0] ##1 (!REG_WR && !SOFT_RESET)[*4]
        |-> TRIM_VALUE == `TRIM_DEFAULT_VALUE) else $error("default trim not applied");
    busy_status_a: assert property (ctrl_rd && CAL_BUSY |=> !REG_RDATA[7] && !REG_RDATA[5]
        && (REG_RDATA[6] || REG_RDATA[4])) else $error("status wrong while running");
endmodule
`default_nettype wire

// ===== tb/calibration_memory_control_tb.sv
// self-checking testbench of the calibration memory control
`timescale 1ns/10ps
`default_nettype none
`include "cal_state_field_defs.svh"

module calibration_memory_control_tb;
    localparam int SC_TICKS = 300;
    localparam int CP_TICKS = 260;
    logic       MCLK, RESET_N, SOFT_RESET, REG_WR, REG_RD, CAL_BUSY;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, FACTORY_ADDR, TRIM_INDEX;
    logic [5:0] FACTORY_DATA, CAL_RESULT, TRIM_VALUE;
    int         err_total;
    int         checks;
    int         n;

    // factory array model, combinational read
    assign FACTORY_DATA = FACTORY_ADDR[5:0] ^ 6'h15;

    calibration_memory_control #(.SELF_CAL_TICKS(SC_TICKS), .COPY_TICKS(CP_TICKS)) dut_u (
        .MCLK(MCLK), .RESET_N(RESET_N), .SOFT_RESET(SOFT_RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .FACTORY_ADDR(FACTORY_ADDR), .FACTORY_DATA(FACTORY_DATA), .CAL_RESULT(CAL_RESULT),
        .TRIM_INDEX(TRIM_INDEX), .TRIM_VALUE(TRIM_VALUE), .CAL_BUSY(CAL_BUSY));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs move on the falling edge, the rising edge takes them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        @(negedge MCLK);
        REG_WR = 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(negedge MCLK);
        REG_ADDR = a;
        REG_RD = 1'b1;
        @(negedge MCLK);
        REG_RD = 1'b0;
        check(what, REG_RDATA, exp);
    endtask
    // trim output is registered, so two edges pass before sampling
    task automatic trim_chk(input logic [7:0] idx, input logic [5:0] exp);
        @(negedge MCLK);
        TRIM_INDEX = idx;
        repeat (2) @(negedge MCLK);
        check("trim", {2'h0, TRIM_VALUE}, {2'h0, exp});
    endtask
    task automatic run_len(input int exp, input int tick);
        n = 0;
        while (CAL_BUSY === 1'b1 && n < 40000) begin
            @(negedge MCLK);
            n++;
        end
        check("cycle length", {7'h0, n >= exp - tick - 4 && n <= exp + tick + 4}, 8'h01);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk("address", `TRIM_ADDR_OFFSET, 8'h00);
        rd_chk("data", `TRIM_DATA_OFFSET, 8'h00);
        rd_chk("config", `CAL_CFG_OFFSET, 8'h00);
        rd_chk("control", `CAL_CTRL_OFFSET, 8'h00);
        rd_chk("unmapped", 8'h12, 8'h00);
        trim_chk(8'h00, 6'h3f);
    endtask
    task automatic t_user();
        wr(`CAL_CTRL_OFFSET, 8'h08);
        wr(`TRIM_ADDR_OFFSET, 8'h05);
        wr(`TRIM_DATA_OFFSET, 8'h2a);
        trim_chk(8'h05, 6'h2a);
        trim_chk(8'h04, 6'h3f);
        wr(`CAL_CTRL_OFFSET, 8'h04);
        wr(`TRIM_DATA_OFFSET, 8'h11);
        rd_chk("work read", `TRIM_DATA_OFFSET, 8'h2a);
        rd_chk("user source", `CAL_CFG_OFFSET, 8'h30);
    endtask
    // soft reset keeps memory and address but reports uncalibrated
    task automatic t_soft();
        @(negedge MCLK);
        SOFT_RESET = 1'b1;
        @(negedge MCLK);
        SOFT_RESET = 1'b0;
        rd_chk("soft source", `CAL_CFG_OFFSET, 8'h00);
        trim_chk(8'h05, 6'h2a);
        rd_chk("soft address", `TRIM_ADDR_OFFSET, 8'h05);
    endtask
    task automatic t_fact_read();
        wr(`CAL_CTRL_OFFSET, 8'h02);
        wr(`TRIM_ADDR_OFFSET, 8'h33);
        check("factory address", FACTORY_ADDR, 8'h33);
        rd_chk("factory read", `TRIM_DATA_OFFSET, 8'h26);
    endtask
    // starts with low control bits set must be ignored
    task automatic t_refuse();
        logic [7:0] bad [2] = '{8'h44, 8'h18};
        foreach (bad[i]) begin
            wr(`CAL_CTRL_OFFSET, bad[i]);
            check("refused busy", {7'h0, CAL_BUSY}, 8'h00);
            rd_chk("refused ctrl", `CAL_CTRL_OFFSET, bad[i] & 8'h0f);
        end
    endtask
    // copy at divider 6, 64 clocks per tick
    task automatic t_copy();
        wr(`CAL_CFG_OFFSET, 8'h06);
        wr(`CAL_CTRL_OFFSET, 8'h10);
        check("copy busy", {7'h0, CAL_BUSY}, 8'h01);
        rd_chk("copy running", `CAL_CTRL_OFFSET, 8'h10);
        run_len(CP_TICKS * 64 - 4, 64);
        rd_chk("copy done", `CAL_CTRL_OFFSET, 8'h20);
        rd_chk("copy source", `CAL_CFG_OFFSET, 8'h26);
        trim_chk(8'h80, 6'h15);
        trim_chk(8'hff, 6'h2a);
    endtask
    // self calibration at divider 7, 32 clocks per tick
    task automatic t_self();
        wr(`CAL_CFG_OFFSET, 8'h07);
        // a soft reset first aborts one launch, which must leave no done flag
        wr(`CAL_CTRL_OFFSET, 8'h40);
        @(negedge MCLK);
        SOFT_RESET = 1'b1;
        @(negedge MCLK);
        SOFT_RESET = 1'b0;
        check("abort busy", {7'h0, CAL_BUSY}, 8'h00);
        rd_chk("abort flags", `CAL_CTRL_OFFSET, 8'h00);
        wr(`CAL_CTRL_OFFSET, 8'h40);
        check("cal busy", {7'h0, CAL_BUSY}, 8'h01);
        run_len(SC_TICKS * 32 - 2, 32);
        rd_chk("cal done", `CAL_CTRL_OFFSET, 8'h80);
        rd_chk("cal source", `CAL_CFG_OFFSET, 8'h17);
        trim_chk(8'h00, 6'h11);
        trim_chk(8'hff, 6'h11);
    endtask
    task automatic t_force();
        wr(`CAL_CTRL_OFFSET, 8'h01);
        repeat (5) @(negedge MCLK);
        trim_chk(8'h80, 6'h3f);
        rd_chk("force ctrl", `CAL_CTRL_OFFSET, 8'h81);
        rd_chk("force source", `CAL_CFG_OFFSET, 8'h07);
        wr(`CAL_CTRL_OFFSET, 8'h00);
        trim_chk(8'hff, 6'h3f);
        rd_chk("force cleared", `CAL_CTRL_OFFSET, 8'h80);
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic results();
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end
    // all scenarios need about 26400 clocks
    initial begin
        repeat (60000) @(posedge MCLK);
        err_total++;
        results();
    end
    initial begin
        err_total = 0;
        checks = 0;
        {RESET_N, SOFT_RESET, REG_WR, REG_RD} = 4'h0;
        {REG_ADDR, REG_WDATA, TRIM_INDEX} = 24'h0;
        CAL_RESULT = 6'h11;
        repeat (6) @(posedge MCLK);
        @(negedge MCLK);
        RESET_N = 1'b1;
        t_reset();
        t_user();
        t_soft();
        t_fact_read();
        t_refuse();
        t_copy();
        t_self();
        t_force();
        results();
    end
endmodule

bind calibration_memory_control cal_state_field_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
    .SELF_CAL_TICKS(SELF_CAL_TICKS), .COPY_TICKS(COPY_TICKS)) chk_u (
    .MCLK(MCLK), .RESET_N(RESET_N), .SOFT_RESET(SOFT_RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .FACTORY_ADDR(FACTORY_ADDR), .FACTORY_DATA(FACTORY_DATA), .CAL_RESULT(CAL_RESULT),
    .TRIM_INDEX(TRIM_INDEX), .TRIM_VALUE(TRIM_VALUE), .CAL_BUSY(CAL_BUSY));
`default_nettype wire
